// [logic/tacp_port.sv]
// Bus front end and conversion sequencer of the touch converter
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RL1] Match fixed prefix plus two select pins
// [RL2] Last address bit: one read, zero write
// [RL3] Acknowledge matching address in ninth clock
// [RL4] Write: one command byte, acknowledged
// [RL5] Command: config, ref power, conv power, resolution
// [RL6] Config codes pick input or drivers
// [RL7] Mux follows config bits; drivers at acquisition
// [RL8] Power bits set state after command
// [RL9] Reference power latched at write end
// [RL10] Conv power set keeps drivers on after
// [RL11] Resolution bit: zero 12-bit, one 8-bit
// [RL12] No acknowledge for extra written bytes
// [RL13] Acquire after C0 fall until write end
// [RL14] Conversion disconnects mux, keeps position drivers
// [RL15] Master waits 10us before reading
// [RL16] Read sends upper eight result bits first
// [RL17] Second byte: low four bits, four zeros
// [RL18] Acknowledged second byte repeats both bytes
// [RL19] High-speed code not acknowledged; lasts to STOP
// [RL20] Stretch SCL until result is latched
// [RL21] Results are straight unsigned binary
// [RL22] 8-bit mode shorter, one byte suffices
// [RL23] Master clears power bits after power-up
// [RL24] Address mismatch: stay released until START
// [RL25] Reserved code: acknowledge, drivers stay off
module tacp_port #(
   // Arbitrary value; set per product
   parameter logic [4:0] TYPE_PREFIX = 5'h0a
) (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_clk,
   // Bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic dev_sel_hi,
   input wire logic dev_sel_lo,
   // Converter side
   input wire logic [11:0] adc_data,
   output logic [3:0] mux_sel,
   output logic mux_connect,
   output logic conv_active,
   output logic eight_bit_mode,
   // Panel drivers
   output logic x_plus_drv,
   output logic x_minus_drv,
   output logic y_plus_drv,
   output logic y_minus_drv,
   // Power and status
   output logic ref_power_on,
   output logic adc_power_on,
   output logic pen_irq_enable,
   output logic hs_mode
);
   import tacp_pkg::*;

   // ==========================================================
   // Link domain state
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic [1:0] sel_s1;
      logic [1:0] sel_s2;
      logic done_s1;
      logic done_s2;
      logic done_d;
      tacp_link_state_type st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic cmd_ok;
      logic [7:0] cmd;
      logic [7:0] cmd_hold;
      logic [3:0] mux_sel;
      logic acq;
      logic req_tgl;
      logic pending;
      logic [15:0] res_word;
      logic byte_sel;
      logic mack;
      logic hs;
      logic sda_oe_n;
      logic scl_oe_n;
      logic pin_low;
   } tacp_link_type;

   // ==========================================================
   // Converter domain state
   typedef struct packed {
      logic acq_s1;
      logic acq_s2;
      logic req_s1;
      logic req_s2;
      logic req_d;
      tacp_conv_state_type st;
      logic [7:0] cnt;
      logic [7:0] cfg;
      logic [15:0] result;
      logic done_tgl;
      logic [3:0] drv;
      logic mux_conn;
      logic ref_on;
      logic adc_on;
      logic pen_en;
      logic eight;
      logic conv;
   } tacp_conv_type;

   localparam tacp_link_type LINK_RESET = '{
      scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
      sel_s1: 2'h0, sel_s2: 2'h0,
      done_s1: 1'b0, done_s2: 1'b0, done_d: 1'b0,
      st: L_IDLE, cnt: 4'h0, sh: 8'h00, cmd_ok: 1'b0, cmd: CMD_RESET,
      cmd_hold: CMD_RESET, mux_sel: 4'h0, acq: 1'b0,
      req_tgl: 1'b0, pending: 1'b0, res_word: RESULT_RESET,
      byte_sel: 1'b0, mack: 1'b0, hs: 1'b0,
      sda_oe_n: 1'b1, scl_oe_n: 1'b1, pin_low: 1'b0
   };

   localparam tacp_conv_type CONV_RESET = '{
      acq_s1: 1'b0, acq_s2: 1'b0, req_s1: 1'b0, req_s2: 1'b0,
      req_d: 1'b0, st: R_IDLE, cnt: 8'h00, cfg: CMD_RESET,
      result: RESULT_RESET, done_tgl: 1'b0, drv: DRV_OFF,
      mux_conn: 1'b0, ref_on: 1'b0, adc_on: 1'b0, pen_en: 1'b1,
      eight: 1'b0, conv: 1'b0
   };

   tacp_link_type l_r;
   tacp_link_type l_nxt;
   tacp_conv_type c_r;
   tacp_conv_type c_nxt;

   // ==========================================================
   // Helpers

   // Driver set {x+, x-, y+, y-} per configuration code
   function automatic logic [3:0] drive_for(input logic [3:0] code);
      logic [3:0] d;
      d = DRV_OFF;
      unique case (code)
         4'h8: d = 4'b0100;
         4'h9: d = 4'b0001;
         4'ha: d = 4'b0110;
         4'hc: d = 4'b1100;
         4'hd: d = 4'b0011;
         4'he: d = 4'b0110;
         4'hf: d = 4'b0110;
         default: d = DRV_OFF; // see [RL6] see [RL25]
      endcase
      return d;
   endfunction : drive_for

   // Level on SDA for bit cnt of the selected result byte
   function automatic logic tx_bit(input logic [15:0] word,
                                   input logic sel,
                                   input logic [3:0] idx);
      logic [7:0] b;
      b = sel ? word[7:0] : word[15:8]; // see [RL16] see [RL17]
      return b[3'(4'h7 - idx)];
   endfunction : tx_bit

   // ==========================================================
   // Link domain: bit engine on sampled SCL and SDA
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic done_edge;

   always_comb begin
      l_nxt = l_r;
      l_nxt.scl_s1 = scl_in;
      l_nxt.scl_s2 = l_r.scl_s1;
      l_nxt.scl_d = l_r.scl_s2;
      l_nxt.sda_s1 = sda_in;
      l_nxt.sda_s2 = l_r.sda_s1;
      l_nxt.sda_d = l_r.sda_s2;
      l_nxt.sel_s1 = {dev_sel_hi, dev_sel_lo};
      l_nxt.sel_s2 = l_r.sel_s1;
      l_nxt.done_s1 = c_r.done_tgl;
      l_nxt.done_s2 = l_r.done_s1;
      l_nxt.done_d = l_r.done_s2;
      scl_rise = l_r.scl_s2 & ~l_r.scl_d;
      scl_fall = ~l_r.scl_s2 & l_r.scl_d;
      bus_start = l_r.scl_s2 & l_r.scl_d & l_r.sda_d & ~l_r.sda_s2;
      bus_stop = l_r.scl_s2 & l_r.scl_d & ~l_r.sda_d & l_r.sda_s2;
      done_edge = l_r.done_s2 ^ l_r.done_d;

      // Result word is stable in the other domain once its toggle lands
      if (done_edge) begin
         l_nxt.pending = 1'b0;
         l_nxt.res_word = c_r.result;
      end

      if (bus_start || bus_stop) begin
         if (l_r.cmd_ok) begin
            l_nxt.cmd_hold = l_r.cmd; // see [RL9]
            l_nxt.req_tgl = ~l_r.req_tgl; // see [RL13]
            l_nxt.pending = 1'b1;
         end
         l_nxt.acq = 1'b0; // see [RL13]
         l_nxt.cmd_ok = 1'b0;
         l_nxt.sda_oe_n = 1'b1;
         l_nxt.scl_oe_n = 1'b1;
         l_nxt.cnt = 4'h0;
         l_nxt.sh = 8'h00;
         l_nxt.st = bus_start ? L_ADDR : L_IDLE;
         if (bus_stop) begin
            l_nxt.hs = 1'b0; // see [RL19]
         end
      end else begin
         unique case (l_r.st)
            L_IDLE, L_WAIT: begin
               l_nxt.sda_oe_n = 1'b1; // see [RL24]
            end
            L_ADDR, L_CMD, L_DROP: begin
               if (scl_rise && l_r.cnt < ACK_SLOT) begin
                  l_nxt.sh = {l_r.sh[6:0], l_r.sda_s2};
                  l_nxt.cnt = l_r.cnt + 4'h1;
                  if (l_r.st == L_CMD && l_r.cnt < CFG_BITS) begin
                     l_nxt.mux_sel = {l_r.mux_sel[2:0], l_r.sda_s2}; // see [RL7]
                  end
               end else if (scl_fall && l_r.cnt == CFG_BITS &&
                            l_r.st == L_CMD) begin
                  l_nxt.acq = 1'b1; // see [RL13]
               end else if (scl_fall && l_r.cnt == ACK_SLOT) begin
                  l_nxt.cnt = ACK_DONE;
                  unique case (l_r.st)
                     L_ADDR: begin
                        if (l_r.sh[7:1] == {TYPE_PREFIX, l_r.sel_s2}) begin
                           l_nxt.sda_oe_n = 1'b0; // see [RL1] see [RL3]
                        end else if (l_r.sh[7:3] == HS_CODE_PREFIX) begin
                           l_nxt.hs = 1'b1; // see [RL19]
                           l_nxt.st = L_WAIT;
                        end else begin
                           l_nxt.st = L_WAIT; // see [RL24]
                        end
                     end
                     L_CMD: begin
                        l_nxt.sda_oe_n = 1'b0; // see [RL4]
                        l_nxt.cmd = l_r.sh; // see [RL5]
                        l_nxt.cmd_ok = 1'b1;
                     end
                     default: begin
                        l_nxt.sda_oe_n = 1'b1; // see [RL12]
                     end
                  endcase
               end else if (scl_fall && l_r.cnt == ACK_DONE) begin
                  l_nxt.sda_oe_n = 1'b1;
                  l_nxt.cnt = 4'h0;
                  if (l_r.st == L_ADDR && l_r.sh[0]) begin
                     l_nxt.st = L_STRETCH; // see [RL2]
                     l_nxt.scl_oe_n = ~l_nxt.pending; // see [RL20]
                  end else if (l_r.st == L_ADDR) begin
                     l_nxt.st = L_CMD; // see [RL2]
                  end else begin
                     l_nxt.st = L_DROP; // see [RL12]
                  end
               end
            end
            L_STRETCH: begin
               // Hold SCL low until the result word has been taken over
               if (!l_nxt.pending) begin
                  l_nxt.scl_oe_n = 1'b1; // see [RL20]
                  l_nxt.byte_sel = 1'b0;
                  l_nxt.cnt = 4'h0;
                  l_nxt.sda_oe_n = tx_bit(l_nxt.res_word, 1'b0, 4'h0);
                  l_nxt.st = L_TX;
               end else begin
                  l_nxt.scl_oe_n = 1'b0;
               end
            end
            L_TX: begin
               if (scl_rise && l_r.cnt < ACK_SLOT) begin
                  l_nxt.cnt = l_r.cnt + 4'h1;
               end else if (scl_rise && l_r.cnt == ACK_SLOT) begin
                  l_nxt.mack = ~l_r.sda_s2;
                  l_nxt.cnt = ACK_DONE;
               end else if (scl_fall && l_r.cnt < ACK_SLOT) begin
                  l_nxt.sda_oe_n = tx_bit(l_r.res_word, l_r.byte_sel,
                                          l_r.cnt);
               end else if (scl_fall && l_r.cnt == ACK_SLOT) begin
                  l_nxt.sda_oe_n = 1'b1; // see [RL17]
               end else if (scl_fall && l_r.cnt == ACK_DONE) begin
                  l_nxt.cnt = 4'h0;
                  if (l_r.mack) begin
                     l_nxt.byte_sel = ~l_r.byte_sel; // see [RL18]
                     l_nxt.sda_oe_n = tx_bit(l_r.res_word, ~l_r.byte_sel,
                                             4'h0);
                  end else begin
                     l_nxt.sda_oe_n = 1'b1;
                     l_nxt.st = L_WAIT;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         l_r <= LINK_RESET;
      end else begin
         l_r <= l_nxt;
      end
   end

   // ==========================================================
   // Converter domain: power state, timing and result capture
   logic req_edge;

   always_comb begin
      c_nxt = c_r;
      c_nxt.acq_s1 = l_r.acq;
      c_nxt.acq_s2 = c_r.acq_s1;
      c_nxt.req_s1 = l_r.req_tgl;
      c_nxt.req_s2 = c_r.req_s1;
      c_nxt.req_d = c_r.req_s2;
      req_edge = c_r.req_s2 ^ c_r.req_d;

      unique case (c_r.st)
         R_IDLE: begin
            if (req_edge) begin
               // Command word in the link domain is frozen until next write
               c_nxt.cfg = l_r.cmd_hold; // see [RL8]
               c_nxt.ref_on = l_r.cmd_hold[CMD_REF_PWR]; // see [RL9]
               c_nxt.eight = l_r.cmd_hold[CMD_MODE]; // see [RL11]
               c_nxt.cnt = l_r.cmd_hold[CMD_MODE] ? CONV8_CYCLES
                                                  : CONV12_CYCLES; // see [RL22]
               c_nxt.st = R_CONV;
            end
         end
         R_CONV: begin
            if (c_r.cnt == 8'h01) begin
               c_nxt.result = c_r.eight ? {adc_data[11:4], RESULT_PAD8}
                                        : {adc_data, RESULT_PAD}; // see [RL21]
               c_nxt.done_tgl = ~c_r.done_tgl;
               c_nxt.st = R_IDLE;
            end else begin
               c_nxt.cnt = c_r.cnt - 8'h01;
            end
         end
      endcase

      c_nxt.conv = (c_nxt.st == R_CONV);
      c_nxt.mux_conn = c_r.acq_s2; // see [RL14]
      c_nxt.adc_on = c_nxt.conv | c_nxt.cfg[CMD_CONV_PWR]; // see [RL8]
      c_nxt.pen_en = ~c_nxt.cfg[CMD_CONV_PWR] & ~c_r.acq_s2 &
                     ~c_nxt.conv; // see [RL8]
      // Mux code in the link domain is settled before acquisition shows here
      if (c_r.acq_s2) begin
         c_nxt.drv = drive_for(l_r.mux_sel); // see [RL7]
      end else if (c_nxt.conv || c_nxt.cfg[CMD_CONV_PWR]) begin
         c_nxt.drv = drive_for(c_nxt.cfg[7:CMD_CFG_LSB]); // see [RL14] see [RL10]
      end else begin
         c_nxt.drv = DRV_OFF;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         c_r <= CONV_RESET;
      end else begin
         c_r <= c_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign scl_out = l_r.pin_low;
   assign sda_out = l_r.pin_low;
   assign scl_oe_n = l_r.scl_oe_n;
   assign sda_oe_n = l_r.sda_oe_n;
   assign hs_mode = l_r.hs;
   assign mux_sel = l_r.mux_sel;
   assign mux_connect = c_r.mux_conn;
   assign conv_active = c_r.conv;
   assign eight_bit_mode = c_r.eight;
   assign x_plus_drv = c_r.drv[3];
   assign x_minus_drv = c_r.drv[2];
   assign y_plus_drv = c_r.drv[1];
   assign y_minus_drv = c_r.drv[0];
   assign ref_power_on = c_r.ref_on;
   assign adc_power_on = c_r.adc_on;
   assign pen_irq_enable = c_r.pen_en;

endmodule : tacp_port

`default_nettype wire

// [logic/tacp_pkg.sv]
// Shared constants and types of the touch converter command port
package tacp_pkg;

   // ==========================================================
   // Clock and conversion timing
   localparam int REF_CLK_MHZ = 100;
   localparam int BIT_DECISION_NS = 100;
   localparam int BIT_CYCLES = (BIT_DECISION_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int CONV_BITS_12 = 12;
   localparam int CONV_BITS_8 = 8;
   localparam logic [7:0] CONV12_CYCLES = 8'(CONV_BITS_12 * BIT_CYCLES);
   localparam logic [7:0] CONV8_CYCLES = 8'(CONV_BITS_8 * BIT_CYCLES);

   // ==========================================================
   // Bus codes
   localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;
   localparam logic [3:0] CFG_BITS = 4'h4;

   // ==========================================================
   // Command byte fields
   localparam int CMD_CFG_LSB = 4;
   localparam int CMD_REF_PWR = 3;
   localparam int CMD_CONV_PWR = 2;
   localparam int CMD_MODE = 1;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // ==========================================================
   // Reset values and result layout
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [3:0] RESULT_PAD = 4'h0;
   localparam logic [7:0] RESULT_PAD8 = 8'h00;
   localparam logic [3:0] DRV_OFF = 4'h0;

   // ==========================================================
   // State machines
   typedef enum logic [2:0] {
      L_IDLE, L_ADDR, L_CMD, L_DROP, L_STRETCH, L_TX, L_WAIT
   } tacp_link_state_type;

   typedef enum logic {R_IDLE, R_CONV} tacp_conv_state_type;

endpackage : tacp_pkg

// [tb/tacp_port_asserts.sv]
// Concurrent checks on the ports of the touch converter command port
`timescale 1ns/1ps
`default_nettype none
module tacp_port_asserts
   import tacp_pkg::*;
(
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic link_clk,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Converter side
   input wire logic [3:0] mux_sel,
   input wire logic mux_connect,
   input wire logic conv_active,
   input wire logic eight_bit_mode,
   // Drivers and power
   input wire logic x_plus_drv,
   input wire logic x_minus_drv,
   input wire logic y_plus_drv,
   input wire logic y_minus_drv,
   input wire logic adc_power_on,
   input wire logic pen_irq_enable,
   input wire logic hs_mode
);
   logic [7:0] conv_cnt_r;
   logic [3:0] drv;
   assign drv = {x_plus_drv, x_minus_drv, y_plus_drv, y_minus_drv};
   // =====================================
   // Conversion length counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) conv_cnt_r <= 8'h00;
      else conv_cnt_r <= conv_active ? conv_cnt_r + 8'h01 : 8'h00;
   end
   // =====================================
   // Properties
   property p_conv_len;
      @(posedge ref_clk) disable iff (rst) $fell(conv_active) |->
         conv_cnt_r == (eight_bit_mode ? CONV8_CYCLES : CONV12_CYCLES);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("bad length");
   property p_mux_off;
      @(posedge ref_clk) disable iff (rst) conv_active |-> !mux_connect;
   endproperty
   a_mux_off: assert property (p_mux_off) else $error("mux on");
   property p_pos_conv;
      @(posedge ref_clk) disable iff (rst)
         conv_active && mux_sel == 4'hc |-> drv == 4'hc;
   endproperty
   a_pos_conv: assert property (p_pos_conv) else $error("drv off");
   // Drivers switch in the same cycle as mux_connect rises; checked four cycles in
   property p_x_acq;
      @(posedge ref_clk) disable iff (rst) mux_connect &&
         $past(mux_connect, 4) && mux_sel == 4'hc |-> drv == 4'hc;
   endproperty
   a_x_acq: assert property (p_x_acq) else $error("x drv");
   property p_rsv;
      @(posedge ref_clk) disable iff (rst) mux_connect &&
         $past(mux_connect, 4) && mux_sel[1:0] == 2'h3 &&
         mux_sel[3:2] != 2'h3 |-> drv == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("rsv drv");
   property p_pen;
      @(posedge ref_clk) disable iff (rst) !conv_active &&
         !$past(conv_active) && !mux_connect |->
         pen_irq_enable != adc_power_on;
   endproperty
   a_pen: assert property (p_pen) else $error("pen state");
   property p_stop_conv;
      @(posedge ref_clk) disable iff (rst)
         $fell(mux_connect) |-> ##[0:40] conv_active;
   endproperty
   a_stop_conv: assert property (p_stop_conv) else $error("no conv");
   property p_hs_stop;
      @(posedge link_clk) disable iff (rst) $fell(hs_mode) |-> scl_in && sda_in;
   endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("hs end");
   c_conv8: cover property (@(posedge ref_clk) $fell(conv_active) && eight_bit_mode);
   c_hs: cover property (@(posedge link_clk) $rose(hs_mode));
   c_pos: cover property (@(posedge ref_clk) conv_active && mux_sel == 4'hc);
endmodule : tacp_port_asserts
bind tacp_port tacp_port_asserts i_tacp_port_asserts (.*);
`default_nettype wire

// [tb/tacp_master.sv]
// Bus master model driving SCL and SDA of the command port
`timescale 1ns/1ps
`default_nettype none
module tacp_master (
   // Clock
   input wire logic ref_clk,
   // Wire levels
   input wire logic scl,
   input wire logic sda,
   // Master drive, low pulls the wire
   output logic scl_m,
   output logic sda_m,
   // Stretch wait ran out
   output logic stuck
);
   int n;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      stuck = 1'b0;
   end
   // =====================================
   // Bit timing
   task automatic half();
      repeat (40) @(posedge ref_clk);
   endtask : half
   // Device may hold SCL low; bounded so a hang is reported
   task automatic rise();
      scl_m <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (scl !== 1'b1 && n < 5000);
      if (n >= 5000) stuck <= 1'b1;
      half();
   endtask : rise
   // =====================================
   // Conditions and bytes
   task automatic start();
      @(posedge ref_clk);
      sda_m <= 1'b1;
      half();
      rise();
      sda_m <= 1'b0;
      half();
      scl_m <= 1'b0;
   endtask : start
   task automatic stop();
      @(posedge ref_clk);
      sda_m <= 1'b0;
      half();
      rise();
      sda_m <= 1'b1;
      half();
   endtask : stop
   // Nine clocks; last is our own acknowledge or a release
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         repeat (10) @(posedge ref_clk);
         sda_m <= (i < 0) ? last : d[i];
         half();
         rise();
         if (i < 0) ack = sda;
         else q[i] = sda;
         scl_m <= 1'b0;
      end
   endtask : xfer
endmodule : tacp_master
`default_nettype wire

// [tb/tacp_port_test.sv]
// Self-checking bench of the touch converter command port
`timescale 1ns/1ps
`default_nettype none
module tacp_port_test;
   import tacp_pkg::*;
   // Arbitrary type prefix
   localparam logic [4:0] PFX = 5'h0b;
   localparam logic [7:0] AW = {PFX, 2'b01, 1'b0};
   localparam logic [7:0] AR = {PFX, 2'b01, 1'b1};
   logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b0;
   logic dev_sel_hi = 1'b0, dev_sel_lo = 1'b1;
   logic [11:0] adc_data = 12'ha5c;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m, stuck, a;
   logic [3:0] mux_sel;
   logic [7:0] q;
   logic mux_connect, conv_active, eight_bit_mode, hs_mode;
   logic x_plus_drv, x_minus_drv, y_plus_drv, y_minus_drv;
   logic ref_power_on, adc_power_on, pen_irq_enable;
   int n_errors = 0, comparisons = 0;
   // Open-drain wires: any party pulls low
   wire scl = scl_m & (scl_oe_n | scl_out);
   wire sda = sda_m & (sda_oe_n | sda_out);
   wire scl_in = scl;
   wire sda_in = sda;
   wire [3:0] drv = {x_plus_drv, x_minus_drv, y_plus_drv, y_minus_drv};
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end
   tacp_port #(.TYPE_PREFIX(PFX)) i_tacp_port (.*);
   tacp_master i_tacp_master (.*);
   // =====================================
   // Helpers
   task automatic end_of_test();
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic idle(input int c);
      repeat (c) @(posedge ref_clk);
   endtask : idle
   task automatic wr(input logic [7:0] cmd);
      i_tacp_master.start();
      i_tacp_master.xfer(AW, 1'b1, q, a);
      check(8'(a), 8'h00);
      i_tacp_master.xfer(cmd, 1'b1, q, a);
      check(8'(a), 8'h00);
   endtask : wr
   task automatic rd(input logic [7:0] b1, input logic [7:0] b2);
      i_tacp_master.start();
      i_tacp_master.xfer(AR, 1'b1, q, a);
      check(8'(a), 8'h00);
      i_tacp_master.xfer(8'hff, 1'b0, q, a);
      check(q, b1);
      i_tacp_master.xfer(8'hff, 1'b0, q, a);
      check(q, b2);
      i_tacp_master.xfer(8'hff, 1'b1, q, a);
      check(q, b1);
   endtask : rd
   always @(posedge stuck) begin
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      end_of_test();
   end
   // =====================================
   // Main sequence
   initial begin
      // Raised here so both clock domains see a reset edge
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      idle(10);
      wr(8'h00);
      i_tacp_master.stop();
      idle(300);
      check(8'({ref_power_on, adc_power_on, pen_irq_enable}), 8'h01);
      // Wrong select pins: nothing may answer or shift in
      i_tacp_master.start();
      i_tacp_master.xfer({PFX, 2'b10, 1'b0}, 1'b1, q, a);
      check(8'(a), 8'h01);
      i_tacp_master.xfer(8'hc4, 1'b1, q, a);
      check(8'(a), 8'h01);
      i_tacp_master.stop();
      check(8'({mux_connect, mux_sel}), 8'h00);
      wr(8'hc4);
      check(8'({mux_connect, mux_sel}), 8'h1c);
      check(8'(drv), 8'h0c);
      i_tacp_master.xfer(8'h55, 1'b1, q, a);
      check(8'(a), 8'h01);
      i_tacp_master.stop();
      idle(30);
      check(8'({conv_active, mux_connect, drv}), 8'h2c);
      idle(200);
      check(8'({conv_active, eight_bit_mode, drv}), 8'h0c);
      check(8'({ref_power_on, adc_power_on, pen_irq_enable}), 8'h02);
      idle(1000);
      rd(8'ha5, 8'hc0);
      i_tacp_master.stop();
      // High-speed entry, transfers joined by repeated STARTs
      adc_data <= 12'h3e7;
      i_tacp_master.start();
      i_tacp_master.xfer(8'h09, 1'b1, q, a);
      check(8'({a, hs_mode}), 8'h03);
      wr(8'h3a);
      check(8'(drv), 8'h00);
      rd(8'h3e, 8'h00);
      check(8'({hs_mode, eight_bit_mode, ref_power_on, pen_irq_enable}),
            8'h0f);
      i_tacp_master.stop();
      idle(30);
      check(8'(hs_mode), 8'h00);
      wr(8'h00);
      i_tacp_master.stop();
      idle(300);
      check(8'(ref_power_on), 8'h00);
      end_of_test();
   end
endmodule : tacp_port_test
`default_nettype wire
